/* File: shared/ovp_pkg.sv */
// Constants and types shared by the output voltage protection block
package ovp_pkg;
  // Register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] GAIN_OFS = 8'h00;
  localparam logic [7:0] UV_LEVEL_OFS = 8'h04;
  localparam logic [7:0] OV_LEVEL_OFS = 8'h08;
  localparam logic [7:0] SET_LOW_OFS = 8'h0C;
  localparam logic [7:0] SET_HIGH_OFS = 8'h10;
  localparam logic [7:0] FLAG_OFS = 8'h14;
  localparam logic [7:0] ACCEL_OFS = 8'h18;
  localparam logic [7:0] LIVE_OFS = 8'h1C;
  // Field positions and widths
  localparam int UV_BIT = 0;
  localparam int OV_BIT = 1;
  localparam int GAIN_W = 3;
  localparam int LEVEL_W = 4;
  localparam int SET_HIGH_W = 2;
  localparam int REF_W = 10;
  // Reset values
  localparam logic [2:0] GAIN_RST = 3'h0;
  localparam logic [3:0] LEVEL_RST = 4'h0;
  localparam logic [9:0] REF_RST = 10'h000;
  localparam logic [1:0] ACCEL_RST = 2'h0;
  // Voltages are handled in eighths of a millivolt
  localparam int FRAC_BITS = 3;
  localparam int DAC_STEP_MV = 2;
  localparam int LEVEL_BASE_MV = 50;
  localparam int LEVEL_STEP_MV = 30;
  localparam logic [21:0] LEVEL_BASE_E = 22'(LEVEL_BASE_MV << FRAC_BITS);
  localparam logic [21:0] LEVEL_STEP_E = 22'(LEVEL_STEP_MV << FRAC_BITS);
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Gate drive modes, one-hot
  typedef enum logic [3:0] {
    MODE_NORMAL = 4'h1,
    MODE_UV_HIGH = 4'h2,
    MODE_UV_LOW = 4'h4,
    MODE_OV_OFF = 4'h8
  } drive_mode_t;
endpackage : ovp_pkg

/* File: src/output_voltage_protection.sv */
// Output voltage supervision with AXI4-Lite registers and drive override
//
// The register addresses and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
// Overview of operation
// - Set undervoltage flag while sense below threshold
// - UV accelerator: high on to max duty, low
// - Resume normal drive once above UV threshold
// - UV flag sticky; software write clears it
// - UV code picks 50 mV plus 30 mV steps
// - UV threshold is reference minus offset
// - Set overvoltage flag while sense above threshold
// - OV accelerator forces both switches off
// - OV flag sticky until software clears it
// - OV code picks 50 mV plus 30 mV steps
// - OV threshold is reference plus offset
// - Flags set regardless of any interrupt enable
// - Gain code decodes to 1, 1/2..1/8, 2..8
// - Gain register bits 7 to 3 read zero
// - Regulated output is code times step times gain
// - Reference code is high bits over low byte
// - Setpoint low byte and two high bits
module output_voltage_protection #(
  parameter int SENSE_W = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Remote sense readings in millivolts
  input wire logic [SENSE_W-1:0] sense_positive,
  input wire logic [SENSE_W-1:0] sense_negative,
  // Normal switching demand from the modulator
  input wire logic pwm_high_req,
  input wire logic pwm_low_req,
  input wire logic period_start,
  input wire logic max_duty_reached,
  // Gate drive to the power stage
  output logic high_drive,
  output logic low_drive,
  // Regulated output target in eighths of a millivolt
  output logic [16:0] target_output
);
  import ovp_pkg::*;

  localparam int FB_W = 22;

  // Elaboration check on the sense width
  if (SENSE_W < 8 || SENSE_W > 16) begin : g_bad_width
    $error("SENSE_W must lie between 8 and 16");
  end

  typedef struct packed {
    logic [2:0] gain_code;
    logic [3:0] undervolt_level_code;
    logic [3:0] overvolt_level_code;
    logic [7:0] setpoint_low;
    logic [1:0] setpoint_high;
    logic [1:0] accel_en;
    logic undervolt_flag;
    logic overvolt_flag;
    logic uv_live;
    logic ov_live;
    drive_mode_t mode;
    logic high_drive;
    logic low_drive;
    logic [16:0] target;
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [7:0] w_byte;
    logic w_lane;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;

  state_t st_q;
  state_t st_d;

  logic [2:0] shift_amt;
  logic [9:0] reference_code;
  logic [FB_W-1:0] ref_e;
  logic [FB_W-1:0] uv_ofs_e;
  logic [FB_W-1:0] ov_ofs_e;
  logic [FB_W-1:0] uv_thr;
  logic [FB_W-1:0] ov_thr;
  logic [FB_W-1:0] fb_e;
  logic [SENSE_W-1:0] diff_mv;
  logic uv_now;
  logic ov_now;
  logic do_write;
  logic flag_clr_uv;
  logic flag_clr_ov;
  logic [31:0] rd_word;
  logic rd_hit;

  // Gain code to shift: gain = 2^(shift - 3)
  function automatic logic [2:0] gain_shift(input logic [2:0] code);
    case (code)
      3'h1: gain_shift = 3'h2;
      3'h2: gain_shift = 3'h1;
      3'h3: gain_shift = 3'h0;
      3'h4: gain_shift = 3'h4;
      3'h5: gain_shift = 3'h5;
      3'h6: gain_shift = 3'h6;
      default: gain_shift = 3'h3;
    endcase
  endfunction : gain_shift

  // Offset for a level code, 50 mV plus 30 mV per step
  function automatic logic [FB_W-1:0] level_ofs(input logic [3:0] code);
    level_ofs = LEVEL_BASE_E + FB_W'(LEVEL_STEP_E * code);
  endfunction : level_ofs

  // Threshold arithmetic in the reference domain
  always_comb begin
    shift_amt = gain_shift(st_q.gain_code);
    reference_code = {st_q.setpoint_high, st_q.setpoint_low};
    ref_e = FB_W'(reference_code) << (FRAC_BITS + 1);
    uv_ofs_e = level_ofs(st_q.undervolt_level_code);
    ov_ofs_e = level_ofs(st_q.overvolt_level_code);
    uv_thr = ref_e - uv_ofs_e;
    ov_thr = ref_e + ov_ofs_e;
    // Negative differential reads as zero output
    if (sense_positive > sense_negative) begin
      diff_mv = sense_positive - sense_negative;
    end else begin
      diff_mv = '0;
    end
    // Divide by gain: gain 1/8 shifts by six, gain 8 by none
    fb_e = (FB_W'(diff_mv) << 6) >> shift_amt;
    // A reference below the offset leaves no undervoltage window
    uv_now = (ref_e >= uv_ofs_e) && (fb_e < uv_thr);
    ov_now = fb_e > ov_thr;
  end

  // Bus handshakes; each channel is taken once per transaction
  assign s_axi_awready = !st_q.aw_have && !st_q.bvalid;
  assign s_axi_wready = !st_q.w_have && !st_q.bvalid;
  assign s_axi_arready = !st_q.rvalid;
  assign s_axi_bvalid = st_q.bvalid;
  assign s_axi_bresp = st_q.bresp;
  assign s_axi_rvalid = st_q.rvalid;
  assign s_axi_rdata = st_q.rdata;
  assign s_axi_rresp = st_q.rresp;
  assign high_drive = st_q.high_drive;
  assign low_drive = st_q.low_drive;
  assign target_output = st_q.target;

  assign do_write = st_q.aw_have && st_q.w_have && !st_q.bvalid;
  assign flag_clr_uv = do_write && st_q.w_lane &&
    st_q.aw_addr == FLAG_OFS && st_q.w_byte[UV_BIT];
  assign flag_clr_ov = do_write && st_q.w_lane &&
    st_q.aw_addr == FLAG_OFS && st_q.w_byte[OV_BIT];

  // Read multiplexer; unused bits read zero
  always_comb begin
    rd_word = '0;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      GAIN_OFS: rd_word[GAIN_W-1:0] = st_q.gain_code;
      UV_LEVEL_OFS: rd_word[LEVEL_W-1:0] = st_q.undervolt_level_code;
      OV_LEVEL_OFS: rd_word[LEVEL_W-1:0] = st_q.overvolt_level_code;
      SET_LOW_OFS: rd_word[7:0] = st_q.setpoint_low;
      SET_HIGH_OFS: rd_word[SET_HIGH_W-1:0] = st_q.setpoint_high;
      FLAG_OFS: rd_word[1:0] = {st_q.overvolt_flag, st_q.undervolt_flag};
      ACCEL_OFS: rd_word[1:0] = st_q.accel_en;
      LIVE_OFS: rd_word[1:0] = {st_q.ov_live, st_q.uv_live};
      default: rd_hit = 1'b0;
    endcase
  end

  // Next state of the whole block
  always_comb begin
    st_d = st_q;
    // Write address and data may arrive in either order
    if (s_axi_awvalid && s_axi_awready) begin
      st_d.aw_have = 1'b1;
      st_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_d.w_have = 1'b1;
      st_d.w_byte = s_axi_wdata[7:0];
      st_d.w_lane = s_axi_wstrb[0];
    end
    if (do_write) begin
      st_d.aw_have = 1'b0;
      st_d.w_have = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp = RESP_OKAY;
      case (st_q.aw_addr)
        GAIN_OFS: begin
          if (st_q.w_lane) begin
            st_d.gain_code = st_q.w_byte[GAIN_W-1:0];
          end
        end
        UV_LEVEL_OFS: begin
          if (st_q.w_lane) begin
            st_d.undervolt_level_code = st_q.w_byte[LEVEL_W-1:0];
          end
        end
        OV_LEVEL_OFS: begin
          if (st_q.w_lane) begin
            st_d.overvolt_level_code = st_q.w_byte[LEVEL_W-1:0];
          end
        end
        SET_LOW_OFS: begin
          if (st_q.w_lane) begin
            st_d.setpoint_low = st_q.w_byte;
          end
        end
        SET_HIGH_OFS: begin
          if (st_q.w_lane) begin
            st_d.setpoint_high = st_q.w_byte[SET_HIGH_W-1:0];
          end
        end
        ACCEL_OFS: begin
          if (st_q.w_lane) begin
            st_d.accel_en = st_q.w_byte[1:0];
          end
        end
        FLAG_OFS: st_d.bresp = RESP_OKAY;
        LIVE_OFS: st_d.bresp = RESP_OKAY;
        default: st_d.bresp = RESP_SLVERR;
      endcase
    end
    if (st_q.bvalid && s_axi_bready) begin
      st_d.bvalid = 1'b0;
    end
    // Read answer registered one cycle after the address
    if (s_axi_arvalid && s_axi_arready) begin
      st_d.rvalid = 1'b1;
      st_d.rdata = rd_word;
      st_d.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (st_q.rvalid && s_axi_rready) begin
      st_d.rvalid = 1'b0;
    end
    // Sticky flags: a new event beats a clear in the same cycle
    st_d.undervolt_flag = (st_q.undervolt_flag && !flag_clr_uv) ||
      uv_now;
    st_d.overvolt_flag = (st_q.overvolt_flag && !flag_clr_ov) ||
      ov_now;
    st_d.uv_live = uv_now;
    st_d.ov_live = ov_now;
    // Target output = code * 2 mV * gain, in eighths of a mV
    st_d.target = 17'(reference_code) << (shift_amt + 3'h1);
    // Drive mode; overvoltage wins since it removes all drive
    case (st_q.mode)
      MODE_NORMAL: begin
        if (ov_now && st_q.accel_en[OV_BIT]) begin
          st_d.mode = MODE_OV_OFF;
        end else if (uv_now && st_q.accel_en[UV_BIT]) begin
          st_d.mode = MODE_UV_HIGH;
        end
      end
      MODE_UV_HIGH, MODE_UV_LOW: begin
        if (ov_now && st_q.accel_en[OV_BIT]) begin
          st_d.mode = MODE_OV_OFF;
        end else if (!uv_now || !st_q.accel_en[UV_BIT]) begin
          st_d.mode = MODE_NORMAL;
        end else if (period_start) begin
          st_d.mode = MODE_UV_HIGH;
        end else if (max_duty_reached) begin
          st_d.mode = MODE_UV_LOW;
        end
      end
      MODE_OV_OFF: begin
        if (!ov_now || !st_q.accel_en[OV_BIT]) begin
          st_d.mode = MODE_NORMAL;
        end
      end
      default: st_d.mode = MODE_NORMAL;
    endcase
    // Gate drive registered from the mode in force this cycle
    case (st_q.mode)
      MODE_UV_HIGH: begin
        st_d.high_drive = 1'b1;
        st_d.low_drive = 1'b0;
      end
      MODE_UV_LOW: begin
        st_d.high_drive = 1'b0;
        st_d.low_drive = 1'b1;
      end
      MODE_OV_OFF: begin
        st_d.high_drive = 1'b0;
        st_d.low_drive = 1'b0;
      end
      default: begin
        // Never both on, even if the modulator asks
        st_d.high_drive = pwm_high_req;
        st_d.low_drive = pwm_low_req && !pwm_high_req;
      end
    endcase
  end

  // State register with synchronous reset
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_q <= '0;
      st_q.gain_code <= GAIN_RST;
      st_q.undervolt_level_code <= LEVEL_RST;
      st_q.overvolt_level_code <= LEVEL_RST;
      st_q.setpoint_low <= REF_RST[7:0];
      st_q.setpoint_high <= REF_RST[9:8];
      st_q.accel_en <= ACCEL_RST;
      st_q.mode <= MODE_NORMAL;
    end else begin
      st_q <= st_d;
    end
  end
endmodule : output_voltage_protection

/* File: testbench/ovp_chk.sv */
// Port assertions for the output voltage protection block
`timescale 1ns/1ps
module ovp_chk import ovp_pkg::*; #(
  parameter int SENSE_W = 16
) (
  // Clock, reset and register bus
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  // Sense and drive
  input wire logic [SENSE_W-1:0] sense_positive,
  input wire logic [SENSE_W-1:0] sense_negative,
  input wire logic high_drive,
  input wire logic low_drive
);
  // Highest OV threshold any setting reaches, in reference units
  localparam int OV_CEIL = 20368;
  logic [1:0] accel_q;
  logic [1:0] accel_late_q;
  logic wr_go;
  logic ov_big;
  assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready;
  // A negative difference reads as zero in the block, never as a fault
  assign ov_big = accel_late_q[OV_BIT] &&
    sense_positive > sense_negative &&
    32'(sense_positive - sense_negative) > OV_CEIL;
  // Enable shadow; misses writes whose halves arrive apart
  // The late copy matches the edge at which the block applies the write
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      accel_q <= ACCEL_RST;
      accel_late_q <= ACCEL_RST;
    end else begin
      accel_late_q <= accel_q;
      if (wr_go && s_axi_awaddr == ACCEL_OFS && s_axi_wstrb[0]) begin
        accel_q <= s_axi_wdata[1:0];
      end
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  a_bresp_held:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid &&
      $stable(s_axi_bresp)) else $error("write answer dropped");
  a_write_answer:
    assert property (wr_go |-> ##2 s_axi_bvalid)
      else $error("write answer late");
  a_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
  a_write_refused:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answering");
  a_read_refused:
    assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answering");
  a_rdata_upper:
    assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("unused read bits set");
  a_no_shoot:
    assert property (!(high_drive && low_drive))
      else $error("both switches on");
  a_ov_cut:
    assert property (ov_big |-> ##2 (!high_drive && !low_drive))
      else $error("drive not cut on overvoltage");
  c_ov_cut: cover property (ov_big);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
  c_uv_high: cover property (high_drive && !low_drive);
endmodule : ovp_chk

bind output_voltage_protection ovp_chk #(.SENSE_W(SENSE_W)) u_chk (
  .sys_clk(sys_clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .sense_positive(sense_positive),
  .sense_negative(sense_negative), .high_drive(high_drive),
  .low_drive(low_drive)
);

/* File: testbench/power_stage_model.sv */
// Behavioural power stage and remote sense pair
`timescale 1ns/1ps
module power_stage_model #(
  parameter int SENSE_W = 16,
  parameter int GND_MV = 100
) (
  // Gate drive and commanded output in millivolts
  input wire logic high_drive,
  input wire logic low_drive,
  input wire logic [15:0] vout_mv,
  // Remote sense and fault report
  output logic [SENSE_W-1:0] sense_positive,
  output logic [SENSE_W-1:0] sense_negative,
  output logic shoot
);
  // Return line sits above zero so only the difference counts
  assign sense_negative = SENSE_W'(GND_MV);
  assign sense_positive = SENSE_W'(GND_MV) + SENSE_W'(vout_mv);
  // Both switches on would short the supply
  assign shoot = high_drive && low_drive;
endmodule : power_stage_model

/* File: testbench/tb.sv */
// Bench for registers, thresholds and drive overrides
`timescale 1ns/1ps
module tb;
  import ovp_pkg::*;
  // Stimulus, all set at time zero
  logic sys_clk = 1'b0, rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0;
  logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0, phi = 1'b0;
  logic plo = 1'b0, pst = 1'b0, mdr = 1'b0;
  // Holds back the write answer's ready to stall the slave
  logic slow_b = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic [15:0] vout = 16'h3E8;
  // Observed values
  logic awready, wready, bvalid, arready, rvalid, hd, ld, shoot;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd_data;
  logic [15:0] sp, sn;
  logic [16:0] target;
  int err_total = 0;
  int checked = 0;
  output_voltage_protection #(.SENSE_W(16)) DUT (
    .sys_clk(sys_clk), .rst(rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_rdata(rdata),
    .s_axi_arready(arready), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .sense_positive(sp), .sense_negative(sn),
    .pwm_high_req(phi), .pwm_low_req(plo), .period_start(pst),
    .max_duty_reached(mdr), .high_drive(hd), .low_drive(ld),
    .target_output(target)
  );
  power_stage_model #(.SENSE_W(16)) u_stage (
    .high_drive(hd), .low_drive(ld), .vout_mv(vout),
    .sense_positive(sp), .sense_negative(sn), .shoot(shoot)
  );
  always #10 sys_clk = ~sys_clk;
  task automatic print_verdict;
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  // Address and data offered together; each dropped once taken
  // With slow_b set, bready rises only once the answer is seen
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tk, bv;
    @(posedge sys_clk);
    {awaddr, wdata} <= {a, d};
    {awvalid, wvalid, bready} <= {2'h3, !slow_b};
    tk = 1'b0;
    while (!tk) begin
      @(negedge sys_clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      bv = bvalid === 1'b1;
      tk = bv && bready;
      resp = bresp;
      @(posedge sys_clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tk) bready <= 1'b0;
      else if (bv) bready <= 1'b1;
    end
  endtask : wr
  task automatic rd(input logic [7:0] a);
    logic ta, tk;
    @(posedge sys_clk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    tk = 1'b0;
    while (!tk) begin
      @(negedge sys_clk);
      ta = arvalid && arready;
      tk = rvalid === 1'b1;
      {rd_data, resp} = {rdata, rresp};
      @(posedge sys_clk);
      if (ta) arvalid <= 1'b0;
      if (tk) rready <= 1'b0;
    end
  endtask : rd
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
    input string nm);
    rd(a);
    chk(nm, e, rd_data);
  endtask : rdchk
  // Sense reaches the flags one edge on, the drive two
  task automatic set_v(input int v);
    @(posedge sys_clk);
    vout <= 16'(v);
    repeat (3) @(posedge sys_clk);
  endtask : set_v
  task automatic chkd(input logic [1:0] e, input string nm);
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(nm, e, {hd, ld});
  endtask : chkd
  task automatic t_regs;
    rdchk(GAIN_OFS, 32'h0, "gain reset");
    slow_b = 1'b1;
    wr(GAIN_OFS, 32'hFF);
    slow_b = 1'b0;
    rdchk(GAIN_OFS, 32'h7, "gain bits");
    // A write without the low byte lane leaves the register alone
    wstrb <= 4'hE;
    wr(GAIN_OFS, 32'h2);
    wstrb <= 4'hF;
    chk("strobe resp", RESP_OKAY, resp);
    rdchk(GAIN_OFS, 32'h7, "strobe off");
    wr(8'h20, 32'h1);
    chk("bad write", RESP_SLVERR, resp);
    rd(8'h20);
    chk("bad read", RESP_SLVERR, resp);
  endtask : t_regs
  // Every gain code against the target for reference code 500
  task automatic t_gain;
    int e;
    wr(SET_LOW_OFS, 32'hF4);
    wr(SET_HIGH_OFS, 32'hFD);
    rdchk(SET_HIGH_OFS, 32'h1, "setpoint high");
    for (int g = 0; g < 8; g++) begin
      wr(GAIN_OFS, 32'(g));
      e = (g == 0 || g == 7) ? 8000 : (g < 4) ? 8000 >> g : 8000 << (g - 3);
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
      chk("target", 32'(e), 32'(target));
    end
    wr(GAIN_OFS, 32'h0);
  endtask : t_gain
  // At level codes 0, 12 and 15, at the threshold and one millivolt past it, no enables set
  task automatic t_levels;
    int thr;
    int codes[3] = '{0, 12, 15};
    foreach (codes[i]) begin
      thr = LEVEL_BASE_MV + LEVEL_STEP_MV * codes[i];
      wr(UV_LEVEL_OFS, 32'(codes[i]));
      wr(OV_LEVEL_OFS, 32'(codes[i]));
      set_v(1000 - thr);
      rdchk(LIVE_OFS, 32'h0, "uv edge");
      set_v(999 - thr);
      rdchk(LIVE_OFS, 32'h1, "uv trip");
      set_v(1000 + thr);
      rdchk(LIVE_OFS, 32'h0, "ov edge");
      set_v(1001 + thr);
      rdchk(LIVE_OFS, 32'h2, "ov trip");
    end
    set_v(1000);
    rdchk(FLAG_OFS, 32'h3, "sticky");
    wr(FLAG_OFS, 32'h1);
    rdchk(FLAG_OFS, 32'h2, "uv clear");
    wr(FLAG_OFS, 32'h2);
    rdchk(FLAG_OFS, 32'h0, "ov clear");
  endtask : t_levels
  task automatic t_accel;
    wr(UV_LEVEL_OFS, 32'hC);
    set_v(589);
    chkd(2'h0, "uv off");
    // Clearing while the condition stands leaves the flag set
    wr(FLAG_OFS, 32'h1);
    rdchk(FLAG_OFS, 32'h1, "uv clear held");
    wr(ACCEL_OFS, 32'h1);
    chkd(2'h2, "uv high");
    @(posedge sys_clk) mdr <= 1'b1;
    @(posedge sys_clk) mdr <= 1'b0;
    chkd(2'h1, "uv low");
    @(posedge sys_clk) pst <= 1'b1;
    @(posedge sys_clk) pst <= 1'b0;
    chkd(2'h2, "uv period");
    @(posedge sys_clk) plo <= 1'b1;
    set_v(1000);
    chkd(2'h1, "uv resume");
    wr(ACCEL_OFS, 32'h3);
    @(posedge sys_clk) {phi, plo} <= 2'h2;
    set_v(30000);
    chkd(2'h0, "ov off");
    set_v(1000);
    chkd(2'h2, "ov resume");
    chk("shoot", 32'h0, 32'(shoot));
  endtask : t_accel
  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    t_regs;
    t_gain;
    t_levels;
    t_accel;
    print_verdict;
  end
  // Cut a hung run short
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    $display("watchdog expired");
    print_verdict;
  end
endmodule : tb
